// ---- design/adcr_accum.sv ----
// Purpose: Sums a chosen number of conversions and scales the sum down.
// Assumes: One sample per sample_valid_in pulse, synchronous to clock_in.
// Notes:   Reserved count codes behave as the largest legal count.

module adcr_accum #(
    parameter int SAMPLE_W = 12,
    parameter int SUM_W = 22,
    parameter int OUT_W = 16
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,
    // Control
    input wire logic run_in,
    input wire logic [3:0] count_sel_in,
    input wire logic [2:0] shift_in,
    input wire logic wide_in,
    // Samples
    input wire logic sample_valid_in,
    input wire logic [SAMPLE_W-1:0] sample_in,
    // Result
    output logic [OUT_W-1:0] result_out,
    output logic result_valid_out
);

    // ========
    // Elaboration checks
    // ========
    if (SUM_W < SAMPLE_W + 10 || OUT_W < SAMPLE_W || SUM_W < OUT_W) begin : g_bad_width
        $error("adcr_accum: sum must hold 1024 samples and cover the output");
    end

    logic [SUM_W-1:0] sum;
    logic [10:0] count;
    logic [SUM_W-1:0] next_sum;
    logic [SUM_W-1:0] scaled;
    logic [3:0] sel_clamped;
    logic [10:0] target;

    // Reserved codes above the maximum are clamped so the count stays bounded
    always_comb begin
        sel_clamped = (count_sel_in > adcr_pkg::SAMPLE_NUM_MAX) ?
                      adcr_pkg::SAMPLE_NUM_MAX : count_sel_in;
        target = 11'(11'd1 << sel_clamped);
        next_sum = sum + SUM_W'(sample_in);
        scaled = next_sum >> shift_in;
    end

    // Summing and sequence boundaries
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sum <= '0;
            count <= '0;
        end else if (!run_in) begin
            sum <= '0;
            count <= '0;
        end else if (sample_valid_in) begin
            if (count + 11'd1 == target) begin
                sum <= '0;
                count <= '0;
            end else begin
                sum <= next_sum;
                count <= count + 11'd1;
            end
        end
    end

    // Result delivery; narrow modes keep the plain conversion width
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            result_out <= '0;
            result_valid_out <= 1'b0;
        end else begin
            result_valid_out <= run_in && sample_valid_in && (count + 11'd1 == target);
            if (run_in && sample_valid_in && (count + 11'd1 == target)) begin
                if (wide_in) begin
                    result_out <= scaled[OUT_W-1:0];
                end else begin
                    result_out <= OUT_W'(scaled[SAMPLE_W-1:0]);
                end
            end
        end
    end

endmodule

// ---- design/adcr_ctrl_regs.sv ----
// Purpose: Converter control registers on AHB-Lite with synchronized enable and reset.
// Assumes: Single slave on the bus; hready_in is this slave's own hreadyout.
// Notes:   Writes commit with no wait state; reads insert one wait state.
//
// Overview of operation
// - Byte, halfword and word accesses are accepted; each register except the 16-bit result sits in byte lane 0.
// - While access protection is asserted, bus writes to protected registers are ignored.
// - Enable-protected fields change only while the converter is disabled.
// - Reserved bits read as zero; software writes zeros there.
// - Standby-run clear halts the converter in standby; set keeps it running.
// - Enable reads back at once; busy flag covers the synchronization delay.
// - Writing one to software reset clears the control registers and disables; zero does nothing.
// - A write that sets software reset discards its other field updates.
// - Reset bit reads one while ongoing; it and busy clear together.
// - Reference bit 7 enables buffer offset compensation, driven to the buffer.
// - Four-bit reference select chooses internal, supply-derived or external references.
// - Adjust field divides the accumulated result by two to its power.
// - Sample count code n sums two to the n conversions, up to 1024.
// - Resolution code one gives the wide 16-bit averaged output.
// - Reset and enable writes pass the synchronizer before taking effect.

module adcr_ctrl_regs #(
    parameter int SAMPLE_W = 12
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // System status
    input wire logic access_protect_in,
    input wire logic standby_in,
    // Conversion samples
    input wire logic sample_valid_in,
    input wire logic [SAMPLE_W-1:0] sample_in,
    // Converter controls
    output logic enable_active_out,
    output logic converter_halt_out,
    output logic [3:0] reference_select_out,
    output logic ref_buffer_offset_comp_out,
    output logic [1:0] resolution_select_out,
    // Results
    output logic [15:0] result_out,
    output logic result_valid_out
);

    // ========
    // Elaboration checks
    // ========
    if (SAMPLE_W < 1 || SAMPLE_W > 16) begin : g_bad_sample
        $error("adcr_ctrl_regs: sample width must be 1 to 16");
    end

    // ========
    // State
    // ========
    logic dp_valid;
    logic dp_write;
    logic [31:0] dp_addr;
    logic [2:0] dp_size;
    logic rd_pending;

    logic software_reset;
    logic enable;
    logic standby_run;
    logic ref_comp;
    logic [3:0] reference_select;
    logic [2:0] result_adjust_shift;
    logic [3:0] sample_count_select;
    logic [1:0] resolution_select;
    logic sync_busy_flag;
    logic [3:0] sync_count;

    logic addr_accept;
    logic lane0_hit;
    logic [7:0] wr_byte;
    logic wr_ok;
    logic [7:0] wr_index;
    logic converter_enabled;
    logic main_wr;
    logic sync_done;
    logic accum_run;
    logic [15:0] accum_result;
    logic accum_valid;
    logic [31:0] next_rdata;

    // ========
    // Bus front end
    // ========

    // Address phase is taken only when the bus is ready
    assign addr_accept = hsel_in && htrans_in[1] && hready_in;

    // Data-phase capture of the address phase
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= '0;
            dp_size <= '0;
        end else if (hready_in) begin
            dp_valid <= addr_accept;
            dp_write <= addr_accept && hwrite_in;
            dp_addr <= haddr_in;
            dp_size <= hsize_in;
        end
    end

    // Lane 0 is touched by any word, a low halfword or byte 0
    always_comb begin
        lane0_hit = 1'b1;
        if (dp_size == adcr_pkg::HSIZE_BYTE) begin
            lane0_hit = (dp_addr[1:0] == 2'b00);
        end else if (dp_size == adcr_pkg::HSIZE_HALF) begin
            lane0_hit = (dp_addr[1] == 1'b0);
        end
    end

    // Upper address bits must be zero so aliases stay unmapped
    assign wr_index = dp_addr[9:2];
    assign wr_byte = hwdata_in[7:0];
    assign wr_ok = dp_valid && dp_write && lane0_hit && (dp_addr[31:10] == 22'h0)
                   && !access_protect_in;

    // ========
    // Synchronized enable and software reset
    // ========
    assign converter_enabled = enable || enable_active_out;
    // Main control writes during a synchronization are dropped to keep one operation in flight
    assign main_wr = wr_ok && (wr_index == adcr_pkg::IDX_MAIN_CTRL) && !sync_busy_flag;
    assign sync_done = sync_busy_flag && (sync_count == 4'h1);

    // Delay counter and busy flag
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync_busy_flag <= 1'b0;
            sync_count <= 4'h0;
        end else if (main_wr && (wr_byte[adcr_pkg::MAIN_SOFT_RESET_BIT]
                     || wr_byte[adcr_pkg::MAIN_ENABLE_BIT] != enable)) begin
            sync_busy_flag <= 1'b1;
            sync_count <= adcr_pkg::SYNC_CYCLES;
        end else if (sync_done) begin
            sync_busy_flag <= 1'b0;
            sync_count <= 4'h0;
        end else if (sync_busy_flag) begin
            sync_count <= sync_count - 4'h1;
        end
    end

    // Main control register; reset bit wins over everything in the same write
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            software_reset <= adcr_pkg::MAIN_CTRL_RESET[adcr_pkg::MAIN_SOFT_RESET_BIT];
            enable <= adcr_pkg::MAIN_CTRL_RESET[adcr_pkg::MAIN_ENABLE_BIT];
            standby_run <= adcr_pkg::MAIN_CTRL_RESET[adcr_pkg::MAIN_STANDBY_BIT];
        end else if (sync_done && software_reset) begin
            software_reset <= 1'b0;
            enable <= 1'b0;
            standby_run <= 1'b0;
        end else if (main_wr) begin
            if (wr_byte[adcr_pkg::MAIN_SOFT_RESET_BIT]) begin
                software_reset <= 1'b1;
            end else begin
                enable <= wr_byte[adcr_pkg::MAIN_ENABLE_BIT];
                standby_run <= wr_byte[adcr_pkg::MAIN_STANDBY_BIT];
            end
        end
    end

    // The converter sees the enable only after the synchronizer delay
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            enable_active_out <= 1'b0;
        end else if (sync_done) begin
            enable_active_out <= software_reset ? 1'b0 : enable;
        end
    end

    // ========
    // Reference, averaging and resolution registers
    // ========

    // Reference control
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ref_comp <= 1'b0;
            reference_select <= adcr_pkg::REF_SEL_RESET;
        end else if (sync_done && software_reset) begin
            ref_comp <= 1'b0;
            reference_select <= adcr_pkg::REF_SEL_RESET;
        end else if (wr_ok && wr_index == adcr_pkg::IDX_REF_CTRL) begin
            ref_comp <= wr_byte[adcr_pkg::REF_COMP_BIT];
            reference_select <= wr_byte[adcr_pkg::REF_SEL_LSB +: 4];
        end
    end

    // Averaging control
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            result_adjust_shift <= adcr_pkg::AVG_ADJ_RESET;
            sample_count_select <= adcr_pkg::AVG_NUM_RESET;
        end else if (sync_done && software_reset) begin
            result_adjust_shift <= adcr_pkg::AVG_ADJ_RESET;
            sample_count_select <= adcr_pkg::AVG_NUM_RESET;
        end else if (wr_ok && wr_index == adcr_pkg::IDX_AVG_CTRL) begin
            result_adjust_shift <= wr_byte[adcr_pkg::AVG_ADJ_LSB +: 3];
            sample_count_select <= wr_byte[adcr_pkg::AVG_NUM_LSB +: 4];
        end
    end

    // Resolution can only change while disabled, so a running sequence never changes output width
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            resolution_select <= adcr_pkg::RES_SEL_RESET;
        end else if (sync_done && software_reset) begin
            resolution_select <= adcr_pkg::RES_SEL_RESET;
        end else if (wr_ok && wr_index == adcr_pkg::IDX_RES_CTRL && !converter_enabled) begin
            resolution_select <= wr_byte[adcr_pkg::RES_SEL_LSB +: 2];
        end
    end

    // ========
    // Analog and converter outputs
    // ========
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            converter_halt_out <= 1'b0;
            reference_select_out <= adcr_pkg::REF_SEL_RESET;
            ref_buffer_offset_comp_out <= 1'b0;
            resolution_select_out <= adcr_pkg::RES_SEL_RESET;
        end else begin
            converter_halt_out <= standby_in && !standby_run;
            reference_select_out <= reference_select;
            ref_buffer_offset_comp_out <= ref_comp;
            resolution_select_out <= resolution_select;
        end
    end

    // Accumulation runs only while enabled and not halted or resetting
    assign accum_run = enable_active_out && !converter_halt_out && !software_reset;

    adcr_accum #(
        .SAMPLE_W(SAMPLE_W),
        .SUM_W(SAMPLE_W + 10),
        .OUT_W(16)
    ) u_accum (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .run_in(accum_run),
        .count_sel_in(sample_count_select),
        .shift_in(result_adjust_shift),
        .wide_in(resolution_select == adcr_pkg::RES_SEL_WIDE),
        .sample_valid_in(sample_valid_in),
        .sample_in(sample_in),
        .result_out(accum_result),
        .result_valid_out(accum_valid)
    );

    // Latest result held for the pins and for reads
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            result_out <= 16'h0000;
            result_valid_out <= 1'b0;
        end else begin
            result_valid_out <= accum_valid;
            if (accum_valid) begin
                result_out <= accum_result;
            end
        end
    end

    // ========
    // Read path
    // ========

    // Read mux; every bit not listed stays zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (dp_addr[31:10] == 22'h0) begin
            unique case (wr_index)
                adcr_pkg::IDX_MAIN_CTRL: begin
                    next_rdata[adcr_pkg::MAIN_SOFT_RESET_BIT] = software_reset;
                    next_rdata[adcr_pkg::MAIN_ENABLE_BIT] = enable;
                    next_rdata[adcr_pkg::MAIN_STANDBY_BIT] = standby_run;
                end
                adcr_pkg::IDX_REF_CTRL: begin
                    next_rdata[adcr_pkg::REF_COMP_BIT] = ref_comp;
                    next_rdata[adcr_pkg::REF_SEL_LSB +: 4] = reference_select;
                end
                adcr_pkg::IDX_AVG_CTRL: begin
                    next_rdata[adcr_pkg::AVG_ADJ_LSB +: 3] = result_adjust_shift;
                    next_rdata[adcr_pkg::AVG_NUM_LSB +: 4] = sample_count_select;
                end
                adcr_pkg::IDX_RES_CTRL: begin
                    next_rdata[adcr_pkg::RES_SEL_LSB +: 2] = resolution_select;
                end
                adcr_pkg::IDX_STATUS: begin
                    next_rdata[adcr_pkg::STATUS_BUSY_BIT] = sync_busy_flag;
                end
                adcr_pkg::IDX_RESULT: begin
                    next_rdata[15:0] = result_out;
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // One wait state on reads so a write just before is always visible
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_pending <= 1'b0;
            hreadyout_out <= 1'b1;
            hrdata_out <= adcr_pkg::RDATA_RESET;
            hresp_out <= 1'b0;
        end else begin
            hresp_out <= 1'b0;
            if (rd_pending) begin
                rd_pending <= 1'b0;
                hreadyout_out <= 1'b1;
                hrdata_out <= next_rdata;
            end else if (addr_accept && !hwrite_in) begin
                rd_pending <= 1'b1;
                hreadyout_out <= 1'b0;
            end
        end
    end

endmodule

// ---- design/adcr_pkg.sv ----
// Purpose: Shared constants for the converter control-register front end.
// Assumes: 32-bit AHB-Lite register bus, one clock at 250 MHz.
// Notes:   Register indices are multiplied by four to form byte addresses.

package adcr_pkg;

    // ========
    // Register indices (byte address is index times four)
    // ========
    localparam logic [7:0] IDX_MAIN_CTRL = 8'h00;
    localparam logic [7:0] IDX_REF_CTRL = 8'h01;
    localparam logic [7:0] IDX_AVG_CTRL = 8'h02;
    localparam logic [7:0] IDX_RES_CTRL = 8'h04;
    localparam logic [7:0] IDX_STATUS = 8'h19;
    localparam logic [7:0] IDX_RESULT = 8'h1A;

    // ========
    // Field positions
    // ========
    localparam int MAIN_SOFT_RESET_BIT = 0;
    localparam int MAIN_ENABLE_BIT = 1;
    localparam int MAIN_STANDBY_BIT = 2;
    localparam int REF_COMP_BIT = 7;
    localparam int REF_SEL_LSB = 0;
    localparam int AVG_NUM_LSB = 0;
    localparam int AVG_ADJ_LSB = 4;
    localparam int RES_SEL_LSB = 4;
    localparam int STATUS_BUSY_BIT = 7;

    // ========
    // Reset values
    // ========
    localparam logic [7:0] MAIN_CTRL_RESET = 8'h00;
    localparam logic [3:0] REF_SEL_RESET = 4'h0;
    localparam logic [3:0] AVG_NUM_RESET = 4'h0;
    localparam logic [2:0] AVG_ADJ_RESET = 3'h0;
    localparam logic [1:0] RES_SEL_RESET = 2'h0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // ========
    // Codes
    // ========
    typedef enum logic [3:0] {
        REF_INTERNAL_ONE_VOLT = 4'h0,
        REF_SUPPLY_DIV_1P48 = 4'h1,
        REF_HALF_SUPPLY = 4'h2,
        REF_EXTERNAL_A = 4'h3,
        REF_EXTERNAL_B = 4'h4
    } adcr_ref_t;

    localparam logic [1:0] RES_SEL_WIDE = 2'h1;
    localparam logic [3:0] SAMPLE_NUM_MAX = 4'hA;

    // AHB-Lite encodings
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;

    // ========
    // Timing
    // ========
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int SYNC_TIME_NS = 12;
    localparam int SYNC_CYCLES_INT = (SYNC_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [3:0] SYNC_CYCLES = 4'(SYNC_CYCLES_INT);

endpackage

// ---- tb/adcr_ctrl_regs_props.sv ----
// Purpose: Port-level checks on the converter control-register front end.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   The sync window is given two cycles of slack early and one cycle late.
module adcr_ctrl_regs_props (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,
    // Bus
    input wire logic hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    // Status and samples
    input wire logic access_protect_in,
    input wire logic standby_in,
    input wire logic sample_valid_in,
    // Converter controls
    input wire logic enable_active_out,
    input wire logic converter_halt_out,
    input wire logic [3:0] reference_select_out,
    input wire logic ref_buffer_offset_comp_out,
    input wire logic [1:0] resolution_select_out,
    input wire logic result_valid_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    logic [3:0] since_wr;
    // ========
    // Helper: cycles since the last accepted write, saturating
    // ========
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            since_wr <= 4'hf;
        end else if (hsel_in && htrans_in[1] && hwrite_in && hreadyout_out) begin
            since_wr <= 4'h0;
        end else if (since_wr != 4'hf) begin
            since_wr <= since_wr + 4'h1;
        end
    end
    // ========
    // Assertions
    // ========
    resp_okay_a: assert property (hresp_out == 1'b0)
        else $error("bus response not OKAY");
    read_wait_a: assert property (hsel_in && htrans_in[1] && !hwrite_in && hreadyout_out
        |=> !hreadyout_out ##1 hreadyout_out) else $error("read wait state wrong");
    write_nowait_a: assert property (hsel_in && htrans_in[1] && hwrite_in && hreadyout_out
        |=> hreadyout_out) else $error("write stalled");
    rdata_hold_a: assert property ($changed(hrdata_out) |-> !$past(hreadyout_out))
        else $error("read data moved outside a read");
    // Four cycles cover a reset already in flight; outputs lag the registers by one
    protect_hold_a: assert property (access_protect_in [*4] |-> ##2
        $stable(reference_select_out) && $stable(resolution_select_out)
        && $stable(ref_buffer_offset_comp_out))
        else $error("control changed under protection");
    res_enable_a: assert property ($changed(resolution_select_out)
        && resolution_select_out != 2'h0 |-> !$past(enable_active_out))
        else $error("resolution changed while enabled");
    halt_cause_a: assert property (converter_halt_out |-> $past(standby_in))
        else $error("halt without standby");
    enable_sync_a: assert property ($changed(enable_active_out)
        |-> since_wr >= 4'h2 && since_wr <= 4'h5) else $error("enable sync delay off");
    result_src_a: assert property (result_valid_out
        |-> $past(sample_valid_in, 2) && $past(enable_active_out, 2))
        else $error("result without enabled sample");
    // Main scenarios reached
    cov_read: cover property (!hreadyout_out ##1 hreadyout_out);
    cov_result: cover property (result_valid_out);
    cov_halt: cover property ($rose(converter_halt_out));
    cov_enable: cover property ($rose(enable_active_out));
endmodule

// ---- tb/adcr_ctrl_regs_tb_top.sv ----
// Purpose: Self-checking bench for the converter control-register front end.
// Assumes: Zero-wait writes, one-wait reads, sync of three cycles.
// Notes:   Table rows cover plain register traffic; hand tests cover the rest.
module adcr_ctrl_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 0, reset_n_in = 0, hsel_in = 0, hwrite_in = 0, standby_in = 0;
    logic access_protect_in = 0, sample_valid_in = 0, hreadyout_out, hresp_out;
    logic enable_active_out, converter_halt_out, ref_buffer_offset_comp_out, result_valid_out;
    logic [31:0] haddr_in = 0, hwdata_in = 0, hrdata_out, v;
    logic [1:0] htrans_in = 0, resolution_select_out;
    logic [2:0] hsize_in = 3'h2;
    logic [11:0] sample_in = 0;
    logic [3:0] reference_select_out;
    logic [15:0] result_out;
    int err_total = 0, check_count = 0, k;
    // Address, write data, expected read back
    logic [15:0] tbl [11][3] = '{'{16'h0004, 16'h0084, 16'h0084}, '{16'h0004, 16'h0001, 16'h0001},
        '{16'h0004, 16'h0002, 16'h0002}, '{16'h0004, 16'h0003, 16'h0003},
        '{16'h0004, 16'h0004, 16'h0004}, '{16'h0004, 16'h0000, 16'h0000},
        '{16'h0008, 16'h007f, 16'h007f}, '{16'h0008, 16'h0012, 16'h0012},
        '{16'h0010, 16'h0010, 16'h0010},
        '{16'h0040, 16'h005a, 16'h0000}, '{16'h0064, 16'h0080, 16'h0000}};
    always #2 clock_in = ~clock_in;
    adcr_ctrl_regs i_adcr_ctrl_regs (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
        .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
        .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
        .access_protect_in(access_protect_in), .standby_in(standby_in),
        .sample_valid_in(sample_valid_in), .sample_in(sample_in),
        .enable_active_out(enable_active_out), .converter_halt_out(converter_halt_out),
        .reference_select_out(reference_select_out), .ref_buffer_offset_comp_out(ref_buffer_offset_comp_out),
        .resolution_select_out(resolution_select_out), .result_out(result_out),
        .result_valid_out(result_valid_out));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One transfer; the master waits on hready, never on a fixed count
    task automatic bus(input logic [31:0] a, input logic w, input logic [2:0] sz,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel_in <= 1'b1;
        haddr_in <= a;
        htrans_in <= 2'h2;
        hwrite_in <= w;
        hsize_in <= sz;
        @(posedge clock_in);
        while (hreadyout_out !== 1'b1) @(posedge clock_in);
        htrans_in <= 2'h0;
        hsel_in <= 1'b0;
        hwdata_in <= wd;
        @(posedge clock_in);
        while (hreadyout_out !== 1'b1) @(posedge clock_in);
        rd = hrdata_out;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] t;
        bus(a, 1'b1, 3'h2, d, t);
    endtask
    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] t;
        bus(a, 1'b0, 3'h2, 32'h0000_0000, t);
        chk(t, exp);
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ========================================================================
    // Watchdog: the whole sequence needs well under a thousand cycles
    // ========================================================================
    initial begin
        repeat (20000) @(posedge clock_in);
        err_total++;
        wrap_up();
    end
    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        repeat (5) @(posedge clock_in);
        reset_n_in <= 1'b1;
        @(posedge clock_in);
        for (k = 0; k < 3; k++) rchk(32'(4 * k), 32'h0000_0000);
        for (k = 0; k < 11; k++) begin
            wr(32'(tbl[k][0]), 32'(tbl[k][1]));
            rchk(32'(tbl[k][0]), 32'(tbl[k][2]));
            if (tbl[k][0] == 16'h0004) chk(32'(reference_select_out), 32'(tbl[k][2][3:0]));
        end
        // Lane 1 byte is refused, lane 0 byte lands
        bus(32'h0000_0005, 1'b1, 3'h0, 32'h0000_0003, v);
        rchk(32'h0000_0004, 32'h0000_0000);
        bus(32'h0000_0004, 1'b1, 3'h0, 32'h0000_0082, v);
        rchk(32'h0000_0004, 32'h0000_0082);
        chk(32'(ref_buffer_offset_comp_out), 32'h0000_0001);
        access_protect_in <= 1'b1;
        wr(32'h0000_0004, 32'h0000_0004);
        rchk(32'h0000_0004, 32'h0000_0082);
        access_protect_in <= 1'b0;
        // Enable reads back at once but acts only after the sync delay
        wr(32'h0000_0000, 32'h0000_0002);
        chk(32'(enable_active_out), 32'h0000_0000);
        rchk(32'h0000_0064, 32'h0000_0080);
        rchk(32'h0000_0000, 32'h0000_0002);
        repeat (6) @(posedge clock_in);
        chk(32'(enable_active_out), 32'h0000_0001);
        rchk(32'h0000_0064, 32'h0000_0000);
        wr(32'h0000_0010, 32'h0000_0000);
        rchk(32'h0000_0010, 32'h0000_0010);
        chk(32'(resolution_select_out), 32'h0000_0001);
        // Four samples summed then halved: 1000 / 2
        for (k = 0; k < 4; k++) begin
            sample_valid_in <= 1'b1;
            sample_in <= 12'(100 * (k + 1));
            @(posedge clock_in);
        end
        sample_valid_in <= 1'b0;
        for (k = 0; k < 40 && result_valid_out !== 1'b1; k++) @(posedge clock_in);
        chk(32'(result_valid_out), 32'h0000_0001);
        chk(32'(result_out), 32'h0000_01f4);
        rchk(32'h0000_0068, 32'h0000_01f4);
        standby_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        chk(32'(converter_halt_out), 32'h0000_0001);
        wr(32'h0000_0000, 32'h0000_0006);
        repeat (3) @(posedge clock_in);
        chk(32'(converter_halt_out), 32'h0000_0000);
        standby_in <= 1'b0;
        wr(32'h0000_0000, 32'h0000_0005);
        rchk(32'h0000_0000, 32'h0000_0007);
        repeat (8) @(posedge clock_in);
        for (k = 0; k < 5; k++) rchk(32'(4 * k), 32'h0000_0000);
        chk(32'(enable_active_out), 32'h0000_0000);
        wrap_up();
    end
endmodule
bind adcr_ctrl_regs adcr_ctrl_regs_props i_adcr_ctrl_regs_props (.clock_in(clock_in),
    .reset_n_in(reset_n_in), .hsel_in(hsel_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .access_protect_in(access_protect_in), .standby_in(standby_in),
    .sample_valid_in(sample_valid_in), .enable_active_out(enable_active_out),
    .converter_halt_out(converter_halt_out), .reference_select_out(reference_select_out),
    .ref_buffer_offset_comp_out(ref_buffer_offset_comp_out),
    .resolution_select_out(resolution_select_out), .result_valid_out(result_valid_out));
